// file: rtl/ext_sram_ctrl.sv
// Purpose: external sync SRAM access with configurable geometry/latency
// Assumes: cpu_req_in is a one-cycle strobe taken only while ready is high
// Notes:   all outputs registered; reserved latency codes behave as 3
`timescale 1ns/1ps
`default_nettype none
module ext_sram_ctrl
  import ext_sram_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // avalon-mm register slave
  input  wire logic [9:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // cpu access path
  input  wire logic        cpu_req_in,
  input  wire logic        cpu_we_in,
  input  wire logic [15:0] cpu_addr_in,
  input  wire logic [15:0] cpu_wdata_in,
  output logic             cpu_ready_out,
  output logic             cpu_ack_out,
  output logic      [15:0] cpu_rdata_out,
  // external memory
  output logic      [17:0] mem_addr_out,
  output logic      [3:0]  mem_bank_out,
  output logic      [1:0]  mem_ce_n_out,
  output logic             mem_we_n_out,
  output logic             mem_oe_n_out,
  output logic      [3:0]  mem_bw_n_out,
  output logic      [31:0] mem_data_out,
  output logic      [3:0]  mem_par_out,
  output logic             mem_data_oe_out,
  input  wire logic [31:0] mem_data_in,
  input  wire logic [3:0]  mem_par_in
);
  // =====================================================================
  // register slave
  logic [31:0] rdata_ff, nxt_rdata;
  logic        wait_ff,  nxt_wait;
  logic [15:0] cfg_ff,   nxt_cfg;
  logic [4:0]  win_ff,   nxt_win;
  logic [3:0]  par_ff,   nxt_par;
  logic [7:0]  reg_idx;
  logic        wr_take;
  logic [15:0] be_mask;

  assign reg_idx = avs_address_in[9:2];
  assign wr_take = avs_write_in & ~wait_ff;
  assign be_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};

  always_comb begin
    // one wait state: waitrequest drops for a single cycle per request
    nxt_wait  = ~((avs_read_in | avs_write_in) & wait_ff);
    nxt_rdata = rdata_ff;
    nxt_cfg   = cfg_ff;
    nxt_win   = win_ff;
    if (avs_read_in && wait_ff) begin
      case (reg_idx)
        IDX_PARITY: nxt_rdata = {28'h0000000, par_ff};
        IDX_CONFIG: nxt_rdata = {16'h0000, cfg_ff};
        IDX_WINDOW: nxt_rdata = {27'h0000000, win_ff};
        default:    nxt_rdata = 32'h00000000;
      endcase
    end
    if (wr_take) begin
      case (reg_idx)
        IDX_CONFIG: begin
          nxt_cfg = (cfg_ff & ~be_mask) | (avs_writedata_in[15:0] & be_mask);
        end
        IDX_WINDOW: begin
          if (avs_byteenable_in[0]) begin
            nxt_win = avs_writedata_in[4:0] & WINDOW_MASK;
          end
        end
        default: begin
          nxt_cfg = cfg_ff; // parity register ignores writes
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h00000000;
      wait_ff  <= 1'b1;
      cfg_ff   <= CONFIG_RESET;
      win_ff   <= WINDOW_RESET[4:0];
    end else begin
      rdata_ff <= nxt_rdata;
      wait_ff  <= nxt_wait;
      cfg_ff   <= nxt_cfg;
      win_ff   <= nxt_win;
    end
  end

  assign avs_readdata_out    = rdata_ff;
  assign avs_waitrequest_out = wait_ff;

  // =====================================================================
  // config decode
  logic [1:0] mode;
  logic       two_chips;
  logic [1:0] lat;
  logic       read_write_turnaround_en_en;
  logic       cross_bank_read_turnaround_en_en;

  assign mode      = cfg_ff[CFG_MODE_LSB +: 2];
  assign two_chips = cfg_ff[CFG_CPB_BIT];
  assign read_write_turnaround_en_en   = cfg_ff[CFG_READ_WRITE_TURNAROUND_EN_BIT];
  assign cross_bank_read_turnaround_en_en   = cfg_ff[CFG_CROSS_BANK_READ_TURNAROUND_EN_BIT];

  always_comb begin
    // reserved codes are a software fault; slowest latency is the safe pick
    case (cfg_ff[CFG_LAT_LSB +: 3])
      LAT_CODE_1: lat = LAT_ONE;
      LAT_CODE_2: lat = LAT_TWO;
      LAT_CODE_3: lat = LAT_THREE;
      default:    lat = LAT_THREE;
    endcase
  end

  // =====================================================================
  // address mapping: window bits sit above the cpu 64K byte address
  logic [DWORD_ADDR_W-1:0] dword_addr;
  logic [DWORD_ADDR_W-1:0] addr_mask;
  logic [DWORD_ADDR_W-1:0] bank_shift;
  logic [MEM_ADDR_W-1:0]   map_addr;
  logic [BANK_W-1:0]       map_bank;
  logic                    odd_word;

  assign dword_addr = {win_ff, cpu_addr_in[15:2]};
  assign odd_word   = cpu_addr_in[1];
  assign addr_mask  = ~({DWORD_ADDR_W{1'b1}} <<
                        (BASE_ADDR_LINES + int'(mode)));
  assign bank_shift = dword_addr >> (BASE_ADDR_LINES + int'(mode));
  assign map_addr   = MEM_ADDR_W'(dword_addr & addr_mask);
  assign map_bank   = bank_shift[BANK_W-1:0];

  // =====================================================================
  // write parity, one bit per byte
  logic [31:0] wr_word;
  logic [3:0]  wr_par;
  logic [3:0]  byte_par;

  assign wr_word = {cpu_wdata_in, cpu_wdata_in};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_par
      assign byte_par[g] = ^wr_word[8*g +: 8] ^ PARITY_ODD;
    end
  endgenerate
  // parity line i belongs to bit 32+i: 0/1 odd word, 2/3 even word
  assign wr_par = {byte_par[2], byte_par[3], byte_par[0], byte_par[1]};

  // =====================================================================
  // access sequencer
  mem_state_t  state_ff,  nxt_state;
  logic [1:0]  cnt_ff,    nxt_cnt;
  logic        we_ff,     nxt_we;
  logic        odd_ff,    nxt_odd;
  logic        last_rd_ff, nxt_last_rd;
  logic [3:0]  last_bank_ff, nxt_last_bank;
  logic [17:0] maddr_ff,  nxt_maddr;
  logic [3:0]  mbank_ff,  nxt_mbank;
  logic [1:0]  ce_n_ff,   nxt_ce_n;
  logic        we_n_ff,   nxt_we_n;
  logic        oe_n_ff,   nxt_oe_n;
  logic [3:0]  bw_n_ff,   nxt_bw_n;
  logic [31:0] mdata_ff,  nxt_mdata;
  logic [3:0]  mpar_ff,   nxt_mpar;
  logic        doe_ff,    nxt_doe;
  logic        ready_ff,  nxt_ready;
  logic        ack_ff,    nxt_ack;
  logic [15:0] crd_ff,    nxt_crd;
  logic        need_turn;
  logic [1:0]  sel_ce_n;

  // with two 16-bit chips only the chip holding the word is enabled
  always_comb begin
    if (two_chips) begin
      sel_ce_n = (state_ff == ST_TURN ? odd_ff : odd_word) ? 2'h2 : 2'h1;
    end else begin
      sel_ce_n = 2'h2;
    end
  end

  assign need_turn = last_rd_ff &
                     ((cpu_we_in & read_write_turnaround_en_en) |
                      (~cpu_we_in & cross_bank_read_turnaround_en_en &
                       (map_bank != last_bank_ff)));

  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_we        = we_ff;
    nxt_odd       = odd_ff;
    nxt_last_rd   = last_rd_ff;
    nxt_last_bank = last_bank_ff;
    nxt_maddr     = maddr_ff;
    nxt_mbank     = mbank_ff;
    nxt_ce_n      = 2'h3;
    nxt_we_n      = 1'b1;
    nxt_oe_n      = 1'b1;
    nxt_bw_n      = 4'hF;
    nxt_mdata     = mdata_ff;
    nxt_mpar      = mpar_ff;
    nxt_doe       = 1'b0;
    nxt_ready     = 1'b0;
    nxt_ack       = 1'b0;
    nxt_crd       = crd_ff;
    nxt_par       = par_ff;
    case (state_ff)
      ST_IDLE, ST_TURN: begin
        if (state_ff == ST_TURN || (cpu_req_in && ready_ff)) begin
          if (state_ff == ST_IDLE) begin
            nxt_we    = cpu_we_in;
            nxt_odd   = odd_word;
            nxt_maddr = map_addr;
            nxt_mbank = map_bank;
            nxt_ce_n  = sel_ce_n;
            nxt_mdata = wr_word;
            nxt_mpar  = wr_par;
          end else begin
            nxt_ce_n  = sel_ce_n;
          end
          if (state_ff == ST_IDLE && need_turn) begin
            nxt_ce_n  = 2'h3; // idle cycle: no command, bus released
            nxt_state = ST_TURN;
          end else begin
            nxt_state = ST_ISSUE;
            nxt_we_n  = ~nxt_we;
            nxt_oe_n  = nxt_we;
            nxt_doe   = nxt_we;
            nxt_bw_n  = ~(nxt_we ? (nxt_odd ? 4'h3 : 4'hC) : 4'h0);
          end
        end else begin
          nxt_ready = 1'b1;
        end
      end
      ST_ISSUE: begin
        nxt_last_bank = mbank_ff;
        nxt_last_rd   = ~we_ff;
        if (we_ff) begin
          nxt_state = ST_IDLE;
          nxt_ack   = 1'b1;
          nxt_ready = 1'b1;
        end else begin
          nxt_state = ST_WAIT;
          nxt_cnt   = lat;
          nxt_oe_n  = 1'b0;
        end
      end
      ST_WAIT: begin
        if (cnt_ff == LAT_ONE) begin
          nxt_state = ST_IDLE;
          nxt_ack   = 1'b1;
          nxt_ready = 1'b1;
          if (odd_ff) begin
            nxt_crd    = mem_data_in[15:0];
            nxt_par[0] = mem_par_in[0];
            nxt_par[1] = mem_par_in[1];
          end else begin
            nxt_crd    = mem_data_in[31:16];
            nxt_par[2] = mem_par_in[2];
            nxt_par[3] = mem_par_in[3];
          end
        end else begin
          nxt_cnt  = cnt_ff - LAT_ONE;
          nxt_oe_n = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_ff     <= ST_IDLE;
      cnt_ff       <= 2'h0;
      we_ff        <= 1'b0;
      odd_ff       <= 1'b0;
      last_rd_ff   <= 1'b0;
      last_bank_ff <= 4'h0;
      maddr_ff     <= 18'h00000;
      mbank_ff     <= 4'h0;
      ce_n_ff      <= 2'h3;
      we_n_ff      <= 1'b1;
      oe_n_ff      <= 1'b1;
      bw_n_ff      <= 4'hF;
      mdata_ff     <= 32'h00000000;
      mpar_ff      <= 4'h0;
      doe_ff       <= 1'b0;
      ready_ff     <= 1'b0;
      ack_ff       <= 1'b0;
      crd_ff       <= 16'h0000;
      par_ff       <= PARITY_RESET[3:0];
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      we_ff        <= nxt_we;
      odd_ff       <= nxt_odd;
      last_rd_ff   <= nxt_last_rd;
      last_bank_ff <= nxt_last_bank;
      maddr_ff     <= nxt_maddr;
      mbank_ff     <= nxt_mbank;
      ce_n_ff      <= nxt_ce_n;
      we_n_ff      <= nxt_we_n;
      oe_n_ff      <= nxt_oe_n;
      bw_n_ff      <= nxt_bw_n;
      mdata_ff     <= nxt_mdata;
      mpar_ff      <= nxt_mpar;
      doe_ff       <= nxt_doe;
      ready_ff     <= nxt_ready;
      ack_ff       <= nxt_ack;
      crd_ff       <= nxt_crd;
      par_ff       <= nxt_par;
    end
  end

  assign cpu_ready_out   = ready_ff;
  assign cpu_ack_out     = ack_ff;
  assign cpu_rdata_out   = crd_ff;
  assign mem_addr_out    = maddr_ff;
  assign mem_bank_out    = mbank_ff;
  assign mem_ce_n_out    = ce_n_ff;
  assign mem_we_n_out    = we_n_ff;
  assign mem_oe_n_out    = oe_n_ff;
  assign mem_bw_n_out    = bw_n_ff;
  assign mem_data_out    = mdata_ff;
  assign mem_par_out     = mpar_ff;
  assign mem_data_oe_out = doe_ff;
endmodule
`default_nettype wire

// file: rtl/ext_sram_pkg.sv
// Purpose: constants for the external sync SRAM config and parity block
// Assumes: 32-bit Avalon-MM slave, register byte address = 4 * index
package ext_sram_pkg;
  // =====================================================================
  // register map (indices; byte address is index * 4)
  localparam logic [7:0]  IDX_WINDOW      = 8'h30;
  localparam logic [7:0]  IDX_PARITY      = 8'h36;
  localparam logic [7:0]  IDX_CONFIG      = 8'h38;
  localparam logic [15:0] PARITY_RESET    = 16'h0000;
  localparam logic [15:0] CONFIG_RESET    = 16'h0000;
  localparam logic [15:0] WINDOW_RESET    = 16'h0000;
  localparam logic [4:0]  WINDOW_MASK     = 5'h1F;
  // =====================================================================
  // config fields
  localparam int CFG_MODE_LSB  = 0;
  localparam int CFG_CPB_BIT   = 2;
  localparam int CFG_LAT_LSB   = 3;
  localparam int CFG_READ_WRITE_TURNAROUND_EN_BIT  = 6;
  localparam int CFG_CROSS_BANK_READ_TURNAROUND_EN_BIT  = 7;
  localparam logic [2:0] LAT_CODE_1 = 3'h1;
  localparam logic [2:0] LAT_CODE_2 = 3'h2;
  localparam logic [2:0] LAT_CODE_3 = 3'h4;
  localparam logic [1:0] LAT_ONE    = 2'h1;
  localparam logic [1:0] LAT_TWO    = 2'h2;
  localparam logic [1:0] LAT_THREE  = 2'h3;
  // =====================================================================
  // memory geometry
  localparam int BASE_ADDR_LINES = 15;
  localparam int MEM_ADDR_W      = 18;
  localparam int BANK_W          = 4;
  localparam int DWORD_ADDR_W    = 19;
  localparam logic PARITY_ODD    = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_TURN  = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT  = 3'b011
  } mem_state_t;
endpackage

// file: sim/ext_sram_ctrl_assertions.sv
// Purpose: port-level checks for the external sram controller
// Assumes: config and window written with all byte lanes enabled
// Notes:   config and window are shadowed from accepted bus writes
`timescale 1ns/1ps
`default_nettype none
module ext_sram_ctrl_assertions
  import ext_sram_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  // register bus
  input wire logic [9:0]  avs_address_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic        avs_waitrequest_out,
  // cpu path
  input wire logic        cpu_req_in,
  input wire logic        cpu_we_in,
  input wire logic [15:0] cpu_addr_in,
  input wire logic        cpu_ready_out,
  input wire logic        cpu_ack_out,
  // memory
  input wire logic [17:0] mem_addr_out,
  input wire logic [3:0]  mem_bank_out,
  input wire logic [1:0]  mem_ce_n_out,
  input wire logic        mem_we_n_out,
  input wire logic        mem_oe_n_out,
  input wire logic [31:0] mem_data_out,
  input wire logic [3:0]  mem_par_out,
  input wire logic        mem_data_oe_out
);
  // ===================================================================
  // shadow state
  logic [7:0]  cfg_ff, nxt_cfg;
  logic [4:0]  win_ff, nxt_win;
  logic [18:0] dw;
  logic [18:0] lim;
  logic [3:0]  bnk;
  logic [1:0]  lat;
  logic        take, rd_iss;
  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_win = win_ff;
    if (avs_write_in && !avs_waitrequest_out) begin
      if (avs_address_in[9:2] == IDX_CONFIG) nxt_cfg = avs_writedata_in[7:0];
      if (avs_address_in[9:2] == IDX_WINDOW) nxt_win = avs_writedata_in[4:0];
    end
    if (!rst_n_in) begin
      nxt_cfg = 8'h00;
      nxt_win = 5'h00;
    end
    dw = {win_ff, cpu_addr_in[15:2]};
    lim = 19'h1 << (BASE_ADDR_LINES + int'(cfg_ff[1:0]));
    bnk = 4'(dw >> (BASE_ADDR_LINES + int'(cfg_ff[1:0])));
    lat = (cfg_ff[5:3] == LAT_CODE_1) ? 2'h1 :
          (cfg_ff[5:3] == LAT_CODE_2) ? 2'h2 : 2'h3;
    take = cpu_req_in && cpu_ready_out;
    rd_iss = (mem_ce_n_out != 2'h3) && mem_we_n_out;
  end
  always_ff @(posedge sys_clk_in) begin
    cfg_ff <= nxt_cfg;
    win_ff <= nxt_win;
  end
  // ===================================================================
  // properties
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_addr_lines;
    mem_ce_n_out != 2'h3 |-> 19'(mem_addr_out) < lim;
  endproperty
  a_addr_lines: assert property (p_addr_lines)
    else $error("address line above selected width driven");
  property p_chip_sel;
    mem_ce_n_out != 2'h3 |->
      (cfg_ff[2] ? mem_ce_n_out != 2'h0 : mem_ce_n_out == 2'h2);
  endproperty
  a_chip_sel: assert property (p_chip_sel)
    else $error("chip enables do not match bank organisation");
  property p_rd_latency;
    rd_iss |-> (lat == 2'h1 ##2 cpu_ack_out) or
      (lat == 2'h2 ##3 cpu_ack_out) or (lat == 2'h3 ##4 cpu_ack_out);
  endproperty
  a_rd_latency: assert property (p_rd_latency)
    else $error("read ack not at configured latency");
  property p_wr_no_turn;
    take && cpu_we_in && !cfg_ff[6] |-> ##2 cpu_ack_out;
  endproperty
  a_wr_no_turn: assert property (p_wr_no_turn)
    else $error("write delayed with turnaround disabled");
  property p_rd_no_turn;
    take && !cpu_we_in && !cfg_ff[7] |-> (lat == 2'h1 ##3 cpu_ack_out) or
      (lat == 2'h2 ##4 cpu_ack_out) or (lat == 2'h3 ##5 cpu_ack_out);
  endproperty
  a_rd_no_turn: assert property (p_rd_no_turn)
    else $error("read delayed with bank turnaround disabled");
  property p_bank_map;
    take && cfg_ff[7:6] == 2'h0 |=> mem_bank_out == $past(bnk) &&
      19'(mem_addr_out) == ($past(dw) & ($past(lim) - 19'h1));
  endproperty
  a_bank_map: assert property (p_bank_map)
    else $error("window bits mapped to wrong lines or bank");
  property p_bus_free;
    !mem_oe_n_out |-> !mem_data_oe_out;
  endproperty
  a_bus_free: assert property (p_bus_free)
    else $error("data bus driven while memory outputs enabled");
  property p_wr_parity;
    !mem_we_n_out |-> mem_data_oe_out && mem_par_out ==
      {^mem_data_out[23:16], ^mem_data_out[31:24],
       ^mem_data_out[7:0], ^mem_data_out[15:8]};
  endproperty
  a_wr_parity: assert property (p_wr_parity)
    else $error("write parity bits wrong");
endmodule
bind ext_sram_ctrl ext_sram_ctrl_assertions i_ext_sram_ctrl_assertions (.*);
`default_nettype wire

// file: sim/sync_sram_model.sv
// Purpose: behavioural synchronous burst sram with parity lines
// Assumes: latency 1 to 3, one issue per cycle
// Notes:   read bus shows a changing pattern when no data is due
`timescale 1ns/1ps
`default_nettype none
module sync_sram_model (
  // controller side
  input  wire logic        clk_in,
  input  wire logic [1:0]  lat_in,
  input  wire logic [17:0] addr_in,
  input  wire logic [3:0]  bank_in,
  input  wire logic [1:0]  ce_n_in,
  input  wire logic        we_n_in,
  input  wire logic [3:0]  bw_n_in,
  input  wire logic [31:0] data_in,
  input  wire logic [3:0]  par_in,
  // read return
  output logic      [31:0] data_out,
  output logic      [3:0]  par_out
);
  // ===================================================================
  // storage and read pipeline
  logic [35:0] mem [logic [21:0]];
  logic [35:0] pd [3];
  logic [2:0]  pv = 3'h0;
  logic [3:0]  cnt = 4'h0;
  logic [21:0] key;
  logic [35:0] q;
  assign key = {bank_in, addr_in};
  always @(posedge clk_in) begin
    q = mem.exists(key) ? mem[key] : 36'h0;
    cnt <= cnt + 4'h1;
    pv <= {pv[1:0], ce_n_in != 2'h3 && we_n_in};
    pd <= '{q, pd[0], pd[1]};
    // halves are kept with the parity that was driven beside them
    if (ce_n_in != 2'h3 && !we_n_in) begin
      if (!bw_n_in[0]) q[17:0] = {par_in[1:0], data_in[15:0]};
      if (!bw_n_in[2]) q[35:18] = {par_in[3:2], data_in[31:16]};
      mem[key] = q;
    end
  end
  assign {par_out[3:2], data_out[31:16], par_out[1:0], data_out[15:0]} =
    pv[lat_in - 2'h1] ? pd[lat_in - 2'h1] : {9{cnt}};
endmodule
`default_nettype wire

// file: sim/test_ext_sync_sram_config_parity.sv
// Purpose: self-checking bench for the external sram controller
// Assumes: bus writes use all byte lanes
// Notes:   random data, windows, mode and chip bits; each latency code run with turnarounds off, then on
`timescale 1ns/1ps
`default_nettype none
module test_ext_sync_sram_config_parity;
  import ext_sram_pkg::*;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0;
  logic [9:0] avs_address_in;
  logic avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [31:0] avs_writedata_in, avs_readdata_out, mem_data_out, mem_data_in;
  logic [3:0] avs_byteenable_in, mem_bank_out, mem_bw_n_out;
  logic [3:0] mem_par_out, mem_par_in;
  logic cpu_req_in, cpu_we_in, cpu_ready_out, cpu_ack_out;
  logic [15:0] cpu_addr_in, cpu_wdata_in, cpu_rdata_out;
  logic [17:0] mem_addr_out;
  logic [1:0] mem_ce_n_out, model_lat = 2'h1;
  logic mem_we_n_out, mem_oe_n_out, mem_data_oe_out;
  int err_total = 0, n_checks = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  ext_sram_ctrl i_ext_sram_ctrl (.*);
  sync_sram_model i_sync_sram_model (.clk_in(sys_clk_in),
    .lat_in(model_lat), .addr_in(mem_addr_out), .bank_in(mem_bank_out),
    .ce_n_in(mem_ce_n_out), .we_n_in(mem_we_n_out), .bw_n_in(mem_bw_n_out),
    .data_in(mem_data_out), .par_in(mem_par_out), .data_out(mem_data_in),
    .par_out(mem_par_in));
  // ===================================================================
  // helpers
  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [15:0] d, output logic [31:0] q);
    @(posedge sys_clk_in);
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_address_in <= {idx, 2'h0};
    avs_writedata_in <= {16'($urandom), d};
    do @(posedge sys_clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic cpu(input logic w, input logic [15:0] a, d, output int n);
    @(posedge sys_clk_in);
    cpu_req_in <= 1'b1;
    cpu_we_in <= w;
    cpu_addr_in <= a;
    cpu_wdata_in <= d;
    do @(posedge sys_clk_in); while (cpu_ready_out !== 1'b1);
    cpu_req_in <= 1'b0;
    n = 1;
    @(negedge sys_clk_in);
    while (cpu_ack_out !== 1'b1) begin
      @(negedge sys_clk_in);
      n++;
    end
  endtask
  function automatic logic [1:0] par2(input logic [15:0] d);
    return {^d[7:0], ^d[15:8]};
  endfunction
  function automatic logic [3:0] bank_of(input logic [4:0] w,
                                         input logic [15:0] a, logic [1:0] m);
    return 4'({w, a[15:2]} >> (BASE_ADDR_LINES + int'(m)));
  endfunction
  // ===================================================================
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    err_total++;
    conclude();
  end
  // ===================================================================
  // main sequence
  initial begin
    logic [7:0] idxs [4] = '{IDX_PARITY, IDX_CONFIG, IDX_WINDOW, 8'h01};
    logic [2:0] codes [3] = '{LAT_CODE_1, LAT_CODE_2, LAT_CODE_3};
    logic [31:0] q;
    logic [15:0] a, d0, d1;
    logic [7:0] cfg;
    logic [4:0] w0, w1;
    logic [3:0] lb, ep;
    logic lr;
    int n;
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} <= '0;
    {cpu_req_in, cpu_we_in, cpu_addr_in, cpu_wdata_in} <= '0;
    avs_byteenable_in <= 4'hF;
    q = $urandom(32'hC652);
    repeat (10) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    bus(1'b1, IDX_PARITY, 16'hFFFF, q);
    bus(1'b1, 8'h01, 16'hFFFF, q);
    foreach (idxs[k]) begin
      bus(1'b0, idxs[k], 16'h0, q);
      check("reset or read-only value", q, 32'h0);
    end
    {lr, lb, ep} = '0;
    for (int i = 0; i < 6; i++) begin
      cfg = {{2{i > 2}}, codes[i % 3], 1'($urandom), 2'($urandom)};
      model_lat <= 2'(i % 3 + 1);
      bus(1'b1, IDX_CONFIG, {8'h00, cfg}, q);
      bus(1'b0, IDX_CONFIG, 16'h0, q);
      check("config", q, {24'h0, cfg});
      {a, d0, d1, w0} = 53'({$urandom, $urandom});
      w1 = (i == 5) ? w0 : 5'($urandom);
      bus(1'b1, IDX_WINDOW, {11'h0, w0}, q);
      cpu(1'b1, a | 16'h2, d0, n);
      check("write ack", 32'(n), 32'(2 + (cfg[6] & lr)));
      bus(1'b1, IDX_WINDOW, {11'h0, w1}, q);
      cpu(1'b1, a & 16'hFFFD, d1, n);
      check("write ack", 32'(n), 32'h2);
      bus(1'b1, IDX_WINDOW, {11'h0, w0}, q);
      cpu(1'b0, a | 16'h2, 16'h0, n);
      check("read ack", 32'(n), 32'(3 + i % 3));
      check("odd data", 32'(cpu_rdata_out), 32'(d0));
      ep[1:0] = par2(d0);
      lb = bank_of(w0, a, cfg[1:0]);
      bus(1'b0, IDX_PARITY, 16'h0, q);
      check("parity odd", q, {28'h0, ep});
      bus(1'b1, IDX_WINDOW, {11'h0, w1}, q);
      cpu(1'b0, a & 16'hFFFD, 16'h0, n);
      check("read ack", 32'(n),
            32'(3 + i % 3 + (cfg[7] && bank_of(w1, a, cfg[1:0]) != lb)));
      check("even data", 32'(cpu_rdata_out), 32'(d1));
      ep[3:2] = par2(d1);
      bus(1'b0, IDX_PARITY, 16'h0, q);
      check("parity even", q, {28'h0, ep});
      lr = 1'b1;
    end
    conclude();
  end
endmodule
`default_nettype wire
